/* core/accel_fifo_pkg.sv */
// Purpose: Shared constants for the accelerometer sample buffer and its host reader.
// Assumes: One 200 MHz clock drives both ends of the register link.
// Notes: Register link is a byte-wide parallel stand-in for the serial port.
package accel_fifo_pkg;

  // ==========================================================================
  // Buffer geometry
  // ==========================================================================
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int AXIS_W = 16;
  localparam int SAMPLE_W = 48;
  localparam int HOST_DEPTH = 16;

  // ==========================================================================
  // Register addresses and fields
  // ==========================================================================
  localparam logic [7:0] ADDR_SRC = 8'h30;
  localparam logic [7:0] ADDR_X0 = 8'h32;
  localparam logic [7:0] ADDR_Z1 = 8'h37;
  localparam logic [7:0] ADDR_CTL = 8'h38;
  localparam logic [7:0] ADDR_STAT = 8'h39;
  localparam int CTL_MODE_POS = 6;
  localparam int CTL_TRIG_POS = 5;
  localparam int CTL_SAMPLES_W = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int STAT_TRIG_POS = 7;
  localparam int SRC_WM_POS = 1;
  localparam int SRC_OVR_POS = 0;

  // Mode field encodings.
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_FIFO = 2'h1;
  localparam logic [1:0] MODE_STREAM = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  localparam int POP_DELAY_NS = 5000;
  localparam int TRIG_DELAY_NS = 5000;
  localparam int POP_CYC = (POP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIG_CYC = (TRIG_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 11;

endpackage

/* core/accel_link_if.sv */
// Purpose: Register link between the sample buffer and the host reader.
// Assumes: Both ends run on clk_sys; read data returns one cycle after the request.
// Notes: Chip select is active low; the interrupt pins travel device to host.
interface accel_link_if;
  logic cs_b;
  logic rd_en;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq_pin_a;
  logic irq_pin_b;

  modport dev(input cs_b, input rd_en, input wr_en, input addr, input wdata,
              output rdata, output irq_pin_a, output irq_pin_b);
  modport host(output cs_b, output rd_en, output wr_en, output addr, output wdata,
               input rdata, input irq_pin_a, input irq_pin_b);
endinterface

/* core/accel_sample_fifo.sv */
// Purpose: Thirty-two entry x/y/z sample buffer with bypass, fifo, stream and trigger modes.
// Assumes: Samples and interrupt sources come from same-clock logic inside the device.
// Notes: The axis data registers hold the popped sample; entries counts what is still buffered.
// What this block does
// RULE1: Bypass stores nothing and reports empty.
// RULE2: Fifo mode stores until 32, then stops.
// RULE3: Watermark sets when count equals sample level.
// RULE4: Full fifo freezes buffer, rest keeps running.
// RULE5: Watermark holds while count not below level.
// RULE6: Stream drops oldest when full, keeps newest.
// RULE7: Untriggered trigger mode keeps newest 32 samples.
// RULE8: Trigger keeps newest n, then fifo behaviour.
// RULE9: Host waits 5 us after trigger.
// RULE10: Further triggers ignored until bypass re-arm.
// RULE11: Bypass empties buffer; host reads first.
// RULE12: Data registers return buffered samples outside bypass.
// RULE13: Each read pops oldest into data registers.
// RULE14: Single byte read still consumes sample.
// RULE15: Host reads all axes in one burst.
// RULE16: Host waits 5 us after data read.
// RULE17: Read ends at 0x37-to-0x38 or deselect.
// RULE18: Fast host deselects between buffer reads.
// RULE19: Two-bit mode field selects buffer mode.
// RULE20: Overrun sets on full, clears on read.
// RULE21: Watermark clears when count drops below level.
// RULE22: Entry holds three 16-bit axes; count 0-32.
// RULE23: Empty read leaves data registers, count unchanged.
module accel_sample_fifo (
  input wire logic clk_sys,
  input wire logic rst_b,
  accel_link_if.dev link,
  input wire logic meas_valid,
  input wire logic [15:0] meas_x,
  input wire logic [15:0] meas_y,
  input wire logic [15:0] meas_z,
  input wire logic irq_src_a,
  input wire logic irq_src_b,
  output logic watermark,
  output logic overrun,
  output logic [5:0] entries
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] mode;
    logic trig_sel;
    logic [4:0] samples;
    logic [accel_fifo_pkg::DEPTH-1:0][accel_fifo_pkg::SAMPLE_W-1:0] mem;
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [5:0] count;
    logic [47:0] out;
    logic loaded;
    logic touched;
    logic triggered;
    logic wm;
    logic ovr;
    logic [7:0] rdata;
    logic [7:0] last_addr;
    logic trig_pin_q;
    logic irq_a;
    logic irq_b;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;

  // Byte view of the state for a register read; unmapped addresses read zero.
  function automatic logic [7:0] read_byte(input dev_state_t st, input logic [7:0] a);
    logic [7:0] b;
    logic [2:0] idx;
    b = 8'h00;
    idx = 3'(a - accel_fifo_pkg::ADDR_X0);
    if (a >= accel_fifo_pkg::ADDR_X0 && a <= accel_fifo_pkg::ADDR_Z1) begin
      b = st.out[idx*8 +: 8];
    end else if (a == accel_fifo_pkg::ADDR_CTL) begin
      b = {st.mode, st.trig_sel, st.samples};
    end else if (a == accel_fifo_pkg::ADDR_STAT) begin
      b = {st.triggered, 1'b0, st.count};
    end else if (a == accel_fifo_pkg::ADDR_SRC) begin
      b = {6'h00, st.wm, st.ovr};
    end
    return b;
  endfunction

  // Combinational local working values.
  logic sel_pin;
  logic trig_evt;
  logic rd_hit;
  logic data_rd;
  logic end_rd;
  logic pop;
  logic ovr_set;
  logic [5:0] cnt;
  logic [4:0] rp;
  logic [4:0] wp;
  logic [7:0] wctl;
  logic full_q;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Order: pins, register access, trim, refill, intake, control write;
  // a write of bypass thus has the last word.
  always_comb begin
    next_s = s;
    cnt = s.count;
    rp = s.rd_ptr;
    wp = s.wr_ptr;
    ovr_set = 1'b0;
    wctl = link.wdata;
    full_q = 1'b0;

    // Interrupt pins are registered copies of the device's event sources.
    next_s.irq_a = irq_src_a;
    next_s.irq_b = irq_src_b;
    sel_pin = s.trig_sel ? s.irq_b : s.irq_a;
    next_s.trig_pin_q = sel_pin;
    trig_evt = (s.mode == accel_fifo_pkg::MODE_TRIGGER) && !s.triggered
               && sel_pin && !s.trig_pin_q; // RULE10

    // Register reads answer one cycle later from the rdata flop.
    rd_hit = !link.cs_b && link.rd_en;
    data_rd = rd_hit && link.addr >= accel_fifo_pkg::ADDR_X0 && link.addr <= accel_fifo_pkg::ADDR_Z1;
    if (rd_hit) begin
      next_s.rdata = read_byte(s, link.addr); // RULE12
      next_s.last_addr = link.addr;
    end
    if (data_rd) begin
      next_s.touched = 1'b1;
    end

    // A data read ends on deselect or on the step from Z1 to the control byte.
    end_rd = s.touched && (link.cs_b || (rd_hit && link.addr == accel_fifo_pkg::ADDR_CTL
             && s.last_addr == accel_fifo_pkg::ADDR_Z1)); // RULE17
    pop = end_rd && s.mode != accel_fifo_pkg::MODE_BYPASS; // RULE14
    if (end_rd) begin
      next_s.touched = data_rd;
    end
    if (pop) begin
      next_s.loaded = 1'b0; // RULE13
    end

    // Trigger trims to the newest n entries and then freezes like fifo mode.
    if (trig_evt) begin
      next_s.triggered = 1'b1; // RULE8
      if (cnt > {1'b0, s.samples}) begin
        rp = wp - s.samples;
        cnt = {1'b0, s.samples};
      end
    end

    // Refill the data registers with the oldest entry when they were consumed.
    if ((!s.loaded || pop) && cnt != 6'h00 && s.mode != accel_fifo_pkg::MODE_BYPASS) begin
      next_s.out = s.mem[rp]; // RULE13
      next_s.loaded = 1'b1;
      rp = rp + 5'h01;
      cnt = cnt - 6'h01;
    end // RULE23

    // Sample intake per mode.
    full_q = cnt == 6'(accel_fifo_pkg::DEPTH);
    if (meas_valid) begin
      unique case (s.mode)
        accel_fifo_pkg::MODE_BYPASS: begin
          next_s.out = {meas_z, meas_y, meas_x}; // RULE1
        end
        accel_fifo_pkg::MODE_FIFO, accel_fifo_pkg::MODE_STREAM, accel_fifo_pkg::MODE_TRIGGER: begin
          // Fifo mode and a fired trigger freeze when full; the rest runs on.
          if (s.mode == accel_fifo_pkg::MODE_FIFO
              || (s.mode == accel_fifo_pkg::MODE_TRIGGER && (s.triggered || trig_evt))) begin
            if (!full_q) begin
              next_s.mem[wp] = {meas_z, meas_y, meas_x}; // RULE2 RULE8 RULE22
              wp = wp + 5'h01;
              cnt = cnt + 6'h01;
              ovr_set = cnt == 6'(accel_fifo_pkg::DEPTH); // RULE20
            end // RULE4
          end else begin
            next_s.mem[wp] = {meas_z, meas_y, meas_x}; // RULE6 RULE7
            wp = wp + 5'h01;
            if (full_q) begin
              rp = rp + 5'h01;
              ovr_set = 1'b1; // RULE20
            end else begin
              cnt = cnt + 6'h01;
              ovr_set = cnt == 6'(accel_fifo_pkg::DEPTH); // RULE20
            end
          end
        end
      endcase
    end

    // Overrun: a new fill wins over the clear from a read in the same cycle.
    next_s.ovr = ovr_set || (s.ovr && !pop); // RULE20

    // Control register write.
    if (!link.cs_b && link.wr_en && link.addr == accel_fifo_pkg::ADDR_CTL) begin
      next_s.mode = wctl[accel_fifo_pkg::CTL_MODE_POS +: 2]; // RULE19
      next_s.trig_sel = wctl[accel_fifo_pkg::CTL_TRIG_POS];
      next_s.samples = wctl[accel_fifo_pkg::CTL_SAMPLES_W-1:0];
      if (wctl[accel_fifo_pkg::CTL_MODE_POS +: 2] == accel_fifo_pkg::MODE_BYPASS) begin
        cnt = 6'h00; // RULE11
        rp = 5'h00;
        wp = 5'h00;
        next_s.triggered = 1'b0; // RULE10
        next_s.ovr = 1'b0;
        next_s.loaded = 1'b0;
      end
    end

    next_s.count = cnt;
    next_s.rd_ptr = rp;
    next_s.wr_ptr = wp;
    // Watermark follows the count both ways; bypass never raises it.
    next_s.wm = next_s.mode != accel_fifo_pkg::MODE_BYPASS
                && cnt >= {1'b0, next_s.samples}; // RULE3 RULE5 RULE21
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Reset gives an empty buffer in bypass, the control reset value being zero.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // All outputs come straight from state flops.
  assign link.rdata = s.rdata;
  assign link.irq_pin_a = s.irq_a;
  assign link.irq_pin_b = s.irq_b;
  assign watermark = s.wm;
  assign overrun = s.ovr;
  assign entries = s.count;

endmodule

/* core/accel_host_reader.sv */
// Purpose: Host end that configures the sample buffer and drains samples into a local queue.
// Assumes: The device answers a read one cycle after the request on the same clock.
// Notes: One countdown timer enforces both the pop gap and the post-trigger gap.

// Parameterised queue holding fetched samples for the user side.
module sample_queue #(
  parameter int W = 48,
  parameter int D = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } q_state_t;

  q_state_t s;
  q_state_t next_s;
  logic do_in;
  logic do_out;

  // Push and pop may coincide; the count only moves when one happens alone.
  always_comb begin
    next_s = s;
    do_in = in_valid && in_ready;
    do_out = out_valid && out_ready;
    if (do_in) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = AW'((s.wp + 1) % D);
    end
    if (do_out) begin
      next_s.rp = AW'((s.rp + 1) % D);
    end
    if (do_in && !do_out) begin
      next_s.cnt = s.cnt + CW'(1);
    end else if (do_out && !do_in) begin
      next_s.cnt = s.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.cnt != CW'(D);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
endmodule

module accel_host_reader (
  input wire logic clk_sys,
  input wire logic rst_b,
  accel_link_if.host link,
  input wire logic cfg_valid,
  input wire logic [1:0] cfg_mode,
  input wire logic cfg_trig_sel,
  input wire logic [4:0] cfg_samples,
  input wire logic rearm,
  input wire logic stat_req,
  input wire logic fetch_req,
  output logic cmd_ready,
  output logic stat_done,
  output logic [5:0] stat_entries,
  output logic stat_triggered,
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [47:0] smp_data
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [2:0] {H_IDLE, H_WRITE, H_READ, H_END, H_STAT} host_st_t;

  typedef struct packed {
    host_st_t st;
    logic cs_b;
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] idx;
    logic [47:0] cap;
    logic [10:0] timer;
    logic push;
    logic rearm_next;
    logic trig_sel;
    logic pin_q;
    logic stat_done;
    logic [5:0] stat_entries;
    logic stat_trig;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic q_ready;
  logic pin;

  // Control byte layout for a write.
  function automatic logic [7:0] ctl_byte(input logic [1:0] m, input logic t, input logic [4:0] n);
    return {m, t, n};
  endfunction

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Commands wait for idle and an expired timer, which keeps both gaps.
  always_comb begin
    next_s = s;
    next_s.push = 1'b0;
    next_s.stat_done = 1'b0;
    if (s.timer != 11'h000) begin
      next_s.timer = s.timer - 11'h001;
    end
    pin = s.trig_sel ? link.irq_pin_b : link.irq_pin_a;
    next_s.pin_q = pin;
    if (pin && !s.pin_q) begin
      next_s.timer = 11'(accel_fifo_pkg::TRIG_CYC); // RULE9
    end
    unique case (s.st)
      H_IDLE: begin
        if (cmd_ready && (cfg_valid || rearm)) begin
          next_s.st = H_WRITE;
          next_s.cs_b = 1'b0;
          next_s.wr_en = 1'b1;
          next_s.addr = accel_fifo_pkg::ADDR_CTL;
          next_s.rearm_next = !cfg_valid; // RULE10
          next_s.trig_sel = cfg_valid ? cfg_trig_sel : s.trig_sel;
          next_s.wdata = cfg_valid ? ctl_byte(cfg_mode, cfg_trig_sel, cfg_samples)
                         : ctl_byte(accel_fifo_pkg::MODE_BYPASS, s.trig_sel, s.wdata[4:0]); // RULE19
        end else if (cmd_ready && (stat_req || (fetch_req && q_ready))) begin
          next_s.st = stat_req ? H_STAT : H_READ;
          next_s.cs_b = 1'b0;
          next_s.rd_en = 1'b1;
          next_s.addr = stat_req ? accel_fifo_pkg::ADDR_STAT : accel_fifo_pkg::ADDR_X0; // RULE15
          next_s.idx = 3'h0;
        end
      end
      H_WRITE: begin
        next_s.wr_en = 1'b0;
        next_s.cs_b = 1'b1;
        next_s.st = H_IDLE;
        if (s.rearm_next) begin
          next_s.rearm_next = 1'b0;
          next_s.st = H_WRITE;
          next_s.cs_b = 1'b0;
          next_s.wr_en = 1'b1;
          next_s.wdata = ctl_byte(accel_fifo_pkg::MODE_TRIGGER, s.trig_sel, s.wdata[4:0]); // RULE10
        end
      end
      H_READ: begin
        // Byte for the previous address arrives now; the seventh issue is the
        // step to the control byte, which closes the read in the device.
        if (s.idx != 3'h0) begin
          next_s.cap[(s.idx - 3'h1)*8 +: 8] = link.rdata;
        end
        next_s.idx = s.idx + 3'h1;
        next_s.addr = s.addr + 8'h01;
        if (s.idx == 3'h6) begin
          next_s.st = H_END;
          next_s.cs_b = 1'b1; // RULE18
          next_s.rd_en = 1'b0;
          next_s.push = 1'b1;
        end
      end
      H_END: begin
        next_s.st = H_IDLE;
        next_s.timer = 11'(accel_fifo_pkg::POP_CYC); // RULE16
      end
      H_STAT: begin
        next_s.rd_en = 1'b0;
        next_s.idx = 3'h1;
        if (s.idx == 3'h1) begin
          next_s.cs_b = 1'b1;
          next_s.st = H_IDLE;
          next_s.stat_done = 1'b1;
          next_s.stat_entries = link.rdata[5:0];
          next_s.stat_trig = link.rdata[accel_fifo_pkg::STAT_TRIG_POS];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: H_IDLE, cs_b: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Queue and outputs
  // ==========================================================================
  sample_queue #(
    .W(accel_fifo_pkg::SAMPLE_W),
    .D(accel_fifo_pkg::HOST_DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(s.push),
    .in_ready(q_ready),
    .in_data(s.cap),
    .out_valid(smp_valid),
    .out_ready(smp_ready),
    .out_data(smp_data)
  );

  assign cmd_ready = s.st == H_IDLE && s.timer == 11'h000;
  assign link.cs_b = s.cs_b;
  assign link.rd_en = s.rd_en;
  assign link.wr_en = s.wr_en;
  assign link.addr = s.addr;
  assign link.wdata = s.wdata;
  assign stat_done = s.stat_done;
  assign stat_entries = s.stat_entries;
  assign stat_triggered = s.stat_trig;

endmodule

/* verification/accel_fifo_asserts.sv */
// Purpose: Concurrent checks on the register link and the buffer status outputs.
// Assumes: Every signal lives in the clk_sys domain.
// Notes: Helper flops shadow the control byte as it crosses the link.
module accel_fifo_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq_pin_a,
  input wire logic irq_pin_b,
  input wire logic watermark,
  input wire logic overrun,
  input wire logic [5:0] entries
);
  logic [1:0] mode_q;
  logic sel_q;
  logic [4:0] lvl_q;
  logic pin_q;
  logic fired_q;
  logic [10:0] gap_q;
  logic rd_ok;
  logic ctl_wr;
  logic pin_now;
  logic byp;

  // Decoded strobes shared by the shadow logic and the properties.
  assign rd_ok = rd_en && !cs_b;
  assign ctl_wr = wr_en && !cs_b && addr == accel_fifo_pkg::ADDR_CTL;
  assign pin_now = sel_q ? irq_pin_b : irq_pin_a;
  assign byp = mode_q == accel_fifo_pkg::MODE_BYPASS;

  // ==========================================================================
  // Shadow state
  // ==========================================================================
  // The gap counter saturates high, so the first read after reset is never flagged.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= accel_fifo_pkg::MODE_BYPASS;
      sel_q <= 1'b0;
      lvl_q <= 5'h00;
      pin_q <= 1'b0;
      fired_q <= 1'b0;
      gap_q <= 11'h7ff;
    end else begin
      pin_q <= pin_now;
      if (ctl_wr) begin
        mode_q <= wdata[7:6];
        sel_q <= wdata[5];
        lvl_q <= wdata[4:0];
      end
      if (ctl_wr && wdata[7:6] == accel_fifo_pkg::MODE_BYPASS) begin
        fired_q <= 1'b0;
      end else if (mode_q == accel_fifo_pkg::MODE_TRIGGER && pin_now && !pin_q) begin
        fired_q <= 1'b1;
      end
      if (rd_ok && addr == accel_fifo_pkg::ADDR_CTL) begin
        gap_q <= 11'h000;
      end else if (gap_q != 11'h7ff) begin
        gap_q <= gap_q + 11'h001;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Properties
  // ==========================================================================
  burst_order_a: assert property (rd_ok && addr >= accel_fifo_pkg::ADDR_X0 && addr <= accel_fifo_pkg::ADDR_Z1
    |=> rd_ok && addr == $past(addr) + 8'h01) else $error("data burst broke its address order");
  pop_gap_a: assert property (rd_ok && (addr == accel_fifo_pkg::ADDR_X0 || addr == accel_fifo_pkg::ADDR_STAT)
    |-> gap_q >= accel_fifo_pkg::POP_CYC) else $error("buffer read came too soon after a pop");
  stat_count_a: assert property (rd_ok && addr == accel_fifo_pkg::ADDR_STAT
    |=> rdata[5:0] == $past(entries)) else $error("status count differs from buffer count");
  rdata_hold_a: assert property (!rd_ok |=> $stable(rdata)) else $error("read data moved without a read");
  bypass_empty_a: assert property (byp [*2] |-> entries == 6'h00) else $error("bypass holds samples");
  wm_set_a: assert property ((!byp && entries >= {1'b0, lvl_q}) [*2]
    |-> watermark) else $error("watermark low at or above level");
  wm_clear_a: assert property ((byp || entries < {1'b0, lvl_q}) [*2]
    |-> !watermark) else $error("watermark high below level");
  count_step_a: assert property (!byp
    |=> entries <= $past(entries) + 6'h01 && entries <= 6'h20) else $error("buffer count jumped or passed full");
  overrun_full_a: assert property (!byp && $rose(entries == 6'h20)
    |-> ##[0:1] overrun) else $error("overrun missing on full buffer");
  trig_trim_a: assert property (mode_q == accel_fifo_pkg::MODE_TRIGGER && !fired_q && pin_now && !pin_q
    |-> ##[0:2] entries <= {1'b0, lvl_q}) else $error("trigger did not trim the buffer");
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench joining the sample buffer to its host reader.
// Assumes: One 200 MHz clock; inputs change 1 ns after each rising edge.
// Notes: A sample k carries k in every low byte and a fixed tag per axis high byte.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic meas_valid = 1'b0, irq_src_a = 1'b0, irq_src_b = 1'b0, cfg_valid = 1'b0, cfg_trig_sel = 1'b0;
  logic rearm = 1'b0, stat_req = 1'b0, fetch_req = 1'b0, smp_ready = 1'b0;
  logic [15:0] meas_x = 16'h0000, meas_y = 16'h0000, meas_z = 16'h0000;
  logic [1:0] cfg_mode = 2'h0;
  logic [4:0] cfg_samples = 5'h00;
  logic watermark, overrun, cmd_ready, stat_done, stat_triggered, smp_valid;
  logic [5:0] entries, stat_entries;
  logic [47:0] smp_data;
  int bad_count = 0, checks_done = 0, cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  accel_link_if link ();
  accel_sample_fifo accel_sample_fifo_i (.clk_sys, .rst_b, .link(link), .meas_valid, .meas_x, .meas_y, .meas_z,
    .irq_src_a, .irq_src_b, .watermark, .overrun, .entries);
  accel_host_reader accel_host_reader_i (.clk_sys, .rst_b, .link(link), .cfg_valid, .cfg_mode, .cfg_trig_sel,
    .cfg_samples, .rearm, .stat_req, .fetch_req, .cmd_ready, .stat_done, .stat_entries, .stat_triggered,
    .smp_valid, .smp_ready, .smp_data);
  accel_fifo_asserts accel_fifo_asserts_i (.clk_sys, .rst_b, .cs_b(link.cs_b), .rd_en(link.rd_en),
    .wr_en(link.wr_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .irq_pin_a(link.irq_pin_a),
    .irq_pin_b(link.irq_pin_b), .watermark, .overrun, .entries);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [47:0] smp(input int k);
    return {8'h30, k[7:0], 8'h20, k[7:0], 8'h10, k[7:0]};
  endfunction

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Requests are one-cycle levels, taken only while cmd_ready is high.
  task automatic cmd(input int k);
    while (cmd_ready !== 1'b1) tick(1);
    {fetch_req, stat_req, rearm, cfg_valid} = 4'(1 << k);
    tick(1);
    {fetch_req, stat_req, rearm, cfg_valid} = 4'h0;
  endtask

  task automatic cfg(input logic [1:0] m, input logic s, input logic [4:0] n);
    cfg_mode = m;
    cfg_trig_sel = s;
    cfg_samples = n;
    cmd(0);
    tick(2);
  endtask

  // Idle cycles keep intake apart from register moves.
  task automatic push(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      {meas_z, meas_y, meas_x} = smp(base + i);
      meas_valid = 1'b1;
      tick(1);
      meas_valid = 1'b0;
      tick(1);
    end
  endtask

  task automatic take(input logic [47:0] exp);
    int w;
    w = 0;
    while (smp_valid !== 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    check(48'(smp_valid), 48'h1);
    check(smp_data, exp);
    smp_ready = 1'b1;
    tick(1);
    smp_ready = 1'b0;
  endtask

  task automatic fetch(input logic [47:0] exp);
    cmd(3);
    take(exp);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Level 1 sits above the empty bypass count, so the watermark stays low even without the bypass exclusion.
  task automatic t_bypass();
    cfg(accel_fifo_pkg::MODE_BYPASS, 1'b0, 5'h01);
    push(3, 0);
    check(48'({watermark, entries}), 48'h0);
    cmd(2);
    tick(3);
    check(48'(stat_entries), 48'h0);
    fetch(smp(2));
  endtask

  // Fills past full, then fills the host queue until it refuses.
  task automatic t_fifo();
    cfg(accel_fifo_pkg::MODE_FIFO, 1'b0, 5'h04);
    push(40, 0);
    check(48'({watermark, overrun, entries}), 48'he0);
    for (int i = 0; i < 16; i++) cmd(3);
    tick(12);
    check(48'(entries), 48'h10);
    cmd(3);
    tick(20);
    check(48'(entries), 48'h10);
    for (int i = 0; i < 16; i++) take(smp(i));
    check(48'(overrun), 48'h0);
    for (int i = 0; i < 13; i++) begin
      fetch(smp(16 + i));
      check(48'(watermark), 48'(15 - i >= 4));
    end
  endtask

  task automatic t_stream();
    cfg(accel_fifo_pkg::MODE_BYPASS, 1'b0, 5'h08);
    cfg(accel_fifo_pkg::MODE_STREAM, 1'b0, 5'h08);
    push(40, 100);
    check(48'({overrun, entries}), 48'h60);
    fetch(smp(100));
    fetch(smp(108));
  endtask

  // Only the pin named by the select bit may fire, and only once per arming.
  task automatic t_trigger();
    cfg(accel_fifo_pkg::MODE_BYPASS, 1'b1, 5'h05);
    cfg(accel_fifo_pkg::MODE_TRIGGER, 1'b1, 5'h05);
    push(40, 0);
    irq_src_a = 1'b1;
    tick(4);
    check(48'(entries), 48'h20);
    irq_src_b = 1'b1;
    tick(4);
    check(48'(entries), 48'h05);
    push(40, 50);
    irq_src_b = 1'b0;
    tick(2);
    irq_src_b = 1'b1;
    tick(4);
    check(48'(entries), 48'h20);
    fetch(smp(0));
    fetch(smp(35));
    irq_src_b = 1'b0;
    cmd(1);
    tick(3);
    check(48'(entries), 48'h0);
    push(10, 200);
    irq_src_b = 1'b1;
    tick(4);
    check(48'(entries), 48'h05);
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic final_report();
    $display("counts: %0d mismatches in %0d checks", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The run needs about 40000 cycles, so this ceiling only trips on a hang.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    tick(5);
    rst_b = 1'b1;
    t_bypass();
    t_fifo();
    t_stream();
    t_trigger();
    final_report();
  end
endmodule
